/* File: shared/sss_consts.svh */
/*
 * Constants for the serial slave unit: frame size, bit positions and
 * semaphore status codes. Guarded, so it may be included more than once per compile unit.
 */
`ifndef SSS_CONSTS_SVH
`define SSS_CONSTS_SVH

`define SSS_BYTE_W 8
`define SSS_LAST_BIT 3'h7
`define SSS_FIRST_BIT 3'h0
`define SSS_STAT_FREE 2'h0
`define SSS_STAT_CPU 2'h1
`define SSS_STAT_SLAVE 2'h2
`define SSS_FIFO_DEPTH 8

`endif

/* File: shared/sss_pkg.sv */
/*
 * Types for the serial slave unit.
 * Assumes nothing of its surroundings.
 */
package sss_pkg;

   typedef enum logic [2:0] {
      SSS_FREE = 3'b001,
      SSS_CPU = 3'b010,
      SSS_SLAVE = 3'b100
   } sss_sem_type;

endpackage

/* File: verilog/sss_slave.sv */
/*
 * Serial slave unit with memory_dma channels and a buffer semaphore, plus
 * the receive FIFO that sits between the link and the memory write port.
 * Assumes a synchronous RAM read port with one cycle of latency and a
 * write port with a ready handshake; link pins are asynchronous.
 */
`timescale 1ns/100ps
`include "sss_consts.svh"

module sss_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 8
) (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [W-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [W-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic push;
   logic pop;

   assign o_in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
   assign o_out_valid = (wr_ptr != rd_ptr);
   assign o_out_data = mem[rd_ptr[AW-1:0]];
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;

   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= i_in_data;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule // sss_fifo

module sss_slave
   import sss_pkg::*;
#(
   parameter int CNT_W = 14,
   parameter int AW = 32
) (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_enable,
   input wire logic i_cpol,
   input wire logic i_cpha,
   input wire logic i_order,
   input wire logic i_acquire,
   input wire logic i_release,
   input wire logic i_short_end_acquire,
   input wire logic i_clear_overflow,
   input wire logic i_clear_tx_flag_a,
   input wire logic [CNT_W-1:0] i_receive_limit,
   input wire logic [CNT_W-1:0] i_transmit_limit,
   input wire logic [AW-1:0] i_rx_buffer_pointer,
   input wire logic [AW-1:0] i_tx_buffer_pointer,
   input wire logic [7:0] i_ignored_fill_char,
   input wire logic [7:0] i_tx_flag_a_fill_char,
   input wire logic i_chip_select_low,
   input wire logic i_sck,
   input wire logic i_mosi,
   output logic o_miso,
   output logic o_miso_oe,
   output logic o_txm_rd,
   output logic [AW-1:0] o_txm_addr,
   input wire logic [7:0] i_txm_data,
   output logic o_rxm_wr,
   output logic [AW-1:0] o_rxm_addr,
   output logic [7:0] o_rxm_data,
   input wire logic i_rxm_ready,
   output logic o_acquired_event,
   output logic o_end_event,
   output logic o_rx_buffer_full_event,
   output logic [1:0] o_sem_status,
   output logic o_overflow,
   output logic o_tx_flag_a,
   output logic [CNT_W-1:0] o_rx_byte_count,
   output logic [CNT_W-1:0] o_tx_byte_count
);
   logic cs_m, cs_s, cs_d;
   logic sck_m, sck_s, sck_d;
   logic mosi_m, mosi_s;
   logic cs_fall, cs_rise, sel;
   logic lead, trail, sample, shift;
   sss_sem_type sem;
   logic pend;
   logic claim, granted, in_xfer;
   logic [2:0] bitc, out_idx, tx_idx;
   logic [7:0] rx_sh, next_rx, tx_byte, tx_next;
   logic byte_done;
   logic [CNT_W-1:0] rx_bytes, tx_cnt, fcnt, rx_wr_idx;
   logic next_valid, first, cur_fill, ret_v, issue;
   logic push, fifo_in_ready, fifo_out_valid, fifo_pop;
   logic [7:0] fifo_out_data;

   // Two-stage synchronisers; edges are judged on stages two and three.
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         {cs_m, cs_s, cs_d} <= 3'h7;
         {sck_m, sck_s, sck_d} <= 3'h0;
         {mosi_m, mosi_s} <= 2'h0;
      end else begin
         {cs_m, cs_s, cs_d} <= {i_chip_select_low, cs_m, cs_s};
         {sck_m, sck_s, sck_d} <= {i_sck, sck_m, sck_s};
         {mosi_m, mosi_s} <= {i_mosi, mosi_m};
      end
   end

   assign sel = !cs_s && i_enable;
   assign cs_fall = !cs_s && cs_d;
   assign cs_rise = cs_s && !cs_d;
   assign lead = ((sck_s ^ i_cpol) && !(sck_d ^ i_cpol));
   assign trail = (!(sck_s ^ i_cpol) && (sck_d ^ i_cpol));
   assign sample = sel && (i_cpha ? trail : lead);
   assign shift = sel && (i_cpha ? lead : trail);
   assign byte_done = sample && (bitc == `SSS_LAST_BIT);
   assign next_rx = i_order ? {mosi_s, rx_sh[7:1]} : {rx_sh[6:0], mosi_s};
   assign tx_idx = i_order ? out_idx : (`SSS_LAST_BIT - out_idx);
   assign claim = i_enable && cs_fall && (sem == SSS_FREE) && !i_acquire;

   // Semaphore ownership.
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         sem <= SSS_CPU;
         pend <= 1'b0;
         o_acquired_event <= 1'b0;
      end else if (!i_enable) begin
         sem <= SSS_CPU;
         pend <= 1'b0;
         o_acquired_event <= 1'b0;
      end else begin
         o_acquired_event <= 1'b0;
         if (cs_rise && granted) begin
            if (pend || i_acquire || i_short_end_acquire) begin
               sem <= SSS_CPU;
               o_acquired_event <= 1'b1;
            end else begin
               sem <= SSS_FREE;
            end
            pend <= 1'b0;
         end else if (i_acquire) begin
            unique case (sem)
               SSS_SLAVE: pend <= 1'b1;
               default: begin
                  sem <= SSS_CPU;
                  o_acquired_event <= 1'b1;
               end
            endcase
         end else if (i_release && (sem == SSS_CPU)) begin
            sem <= SSS_FREE;
         end else if (claim) begin
            sem <= SSS_SLAVE;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_sem_status <= `SSS_STAT_CPU;
      end else begin
         unique case (sem)
            SSS_FREE: o_sem_status <= `SSS_STAT_FREE;
            SSS_SLAVE: o_sem_status <= `SSS_STAT_SLAVE;
            default: o_sem_status <= `SSS_STAT_CPU;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         granted <= 1'b0;
         in_xfer <= 1'b0;
      end else begin
         if (cs_fall && i_enable) begin
            granted <= claim;
            in_xfer <= 1'b1;
         end else if (cs_rise || !i_enable) begin
            granted <= 1'b0;
            in_xfer <= 1'b0;
         end
      end
   end

   // Bit counting and receive shifting.
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         bitc <= `SSS_FIRST_BIT;
         out_idx <= `SSS_FIRST_BIT;
         rx_sh <= 8'h00;
      end else if (cs_fall) begin
         bitc <= `SSS_FIRST_BIT;
         out_idx <= `SSS_FIRST_BIT;
      end else begin
         if (sample) begin
            bitc <= bitc + 3'h1;
            rx_sh <= next_rx;
         end
         if (shift) begin
            out_idx <= bitc;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_miso <= 1'b0;
         o_miso_oe <= 1'b0;
      end else begin
         o_miso <= tx_byte[tx_idx];
         o_miso_oe <= sel && in_xfer;
      end
   end

   // transmit channel reads ahead one byte
   // pointers are read live, never locked
   assign issue = granted && !o_txm_rd && !ret_v && (fcnt < i_transmit_limit)
                  && (first || !next_valid);

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_txm_rd <= 1'b0;
         o_txm_addr <= '0;
         ret_v <= 1'b0;
         fcnt <= '0;
      end else begin
         o_txm_rd <= issue;
         ret_v <= o_txm_rd;
         if (claim) begin
            fcnt <= '0;
         end else if (issue) begin
            fcnt <= fcnt + 1'b1;
            o_txm_addr <= i_tx_buffer_pointer + AW'(fcnt);
         end
      end
   end

   // Transmit byte selection.
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         tx_byte <= 8'h00;
         tx_next <= 8'h00;
         next_valid <= 1'b0;
         first <= 1'b0;
         cur_fill <= 1'b0;
         tx_cnt <= '0;
      end else if (cs_fall && i_enable) begin
         tx_byte <= claim ? i_tx_flag_a_fill_char : i_ignored_fill_char;
         cur_fill <= 1'b1;
         first <= claim && (i_transmit_limit != '0);
         next_valid <= 1'b0;
         tx_cnt <= '0;
      end else if (granted) begin
         if (ret_v && first) begin
            tx_byte <= i_txm_data;
            cur_fill <= 1'b0;
            first <= 1'b0;
            tx_cnt <= tx_cnt + 1'b1;
         end else if (byte_done) begin
            if (next_valid || ret_v) begin
               tx_byte <= next_valid ? tx_next : i_txm_data;
               cur_fill <= 1'b0;
               tx_cnt <= tx_cnt + 1'b1;
               next_valid <= next_valid && ret_v;
               tx_next <= i_txm_data;
            end else begin
               tx_byte <= i_tx_flag_a_fill_char;
               cur_fill <= 1'b1;
            end
         end else if (ret_v) begin
            tx_next <= i_txm_data;
            next_valid <= 1'b1;
         end
      end
   end

   assign push = byte_done && granted && (rx_bytes < i_receive_limit) && fifo_in_ready;

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         rx_bytes <= '0;
         o_rx_buffer_full_event <= 1'b0;
      end else begin
         o_rx_buffer_full_event <= push && ((rx_bytes + 1'b1) == i_receive_limit);
         if (claim) begin
            rx_bytes <= '0;
         end else if (push) begin
            rx_bytes <= rx_bytes + 1'b1;
         end
      end
   end

   // Status flags: a new event wins over a clear in the same cycle.
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_overflow <= 1'b0;
         o_tx_flag_a <= 1'b0;
      end else begin
         if (byte_done && granted && !push) begin
            o_overflow <= 1'b1;
         end else if (i_clear_overflow) begin
            o_overflow <= 1'b0;
         end
         // a fill byte was clocked out
         if (byte_done && granted && cur_fill) begin
            o_tx_flag_a <= 1'b1;
         end else if (i_clear_tx_flag_a) begin
            o_tx_flag_a <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_end_event <= 1'b0;
         o_rx_byte_count <= '0;
         o_tx_byte_count <= '0;
      end else begin
         o_end_event <= cs_rise && granted;
         if (cs_rise && granted) begin
            o_rx_byte_count <= rx_bytes;
            o_tx_byte_count <= tx_cnt;
         end
      end
   end

   sss_fifo #(
      .W(`SSS_BYTE_W),
      .DEPTH(`SSS_FIFO_DEPTH)
   ) u_rx_fifo (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_in_valid(push),
      .o_in_ready(fifo_in_ready),
      .i_in_data(next_rx),
      .o_out_valid(fifo_out_valid),
      .i_out_ready(fifo_pop),
      .o_out_data(fifo_out_data)
   );

   // The output stage is a register so a stalled RAM port holds steady.
   assign fifo_pop = fifo_out_valid && (!o_rxm_wr || i_rxm_ready);

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rxm_wr <= 1'b0;
         o_rxm_addr <= '0;
         o_rxm_data <= 8'h00;
         rx_wr_idx <= '0;
      end else begin
         if (fifo_pop) begin
            o_rxm_wr <= 1'b1;
            o_rxm_data <= fifo_out_data;
            o_rxm_addr <= i_rx_buffer_pointer + AW'(rx_wr_idx);
         end else if (i_rxm_ready) begin
            o_rxm_wr <= 1'b0;
         end
         if (claim) begin
            rx_wr_idx <= '0;
         end else if (fifo_pop) begin
            rx_wr_idx <= rx_wr_idx + 1'b1;
         end
      end
   end
endmodule // sss_slave

/* File: sim/sss_slave_properties.sv */
/* Port checker for sss_slave, bound to every instance of it.
   Assumes status codes 0 free, 1 CPU, 2 slave, and pins held steady by the bench. */
`timescale 1ns/100ps
module sss_slave_properties #(
   parameter int CNT_W = 14,
   parameter int AW = 32
) (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_enable,
   input wire logic i_acquire,
   input wire logic i_release,
   input wire logic i_short_end_acquire,
   input wire logic i_chip_select_low,
   input wire logic [CNT_W-1:0] i_receive_limit,
   input wire logic [AW-1:0] i_rx_buffer_pointer,
   input wire logic o_miso_oe,
   input wire logic o_rxm_wr,
   input wire logic [AW-1:0] o_rxm_addr,
   input wire logic o_acquired_event,
   input wire logic o_end_event,
   input wire logic [1:0] o_sem_status
);
   default clocking @(posedge i_mclk);
   endclocking
   default disable iff (!i_nrst);

   sequence s_deselected;
      i_chip_select_low [*6];
   endsequence
   sequence s_cpu_grant;
      o_acquired_event ##1 o_sem_status == 2'h1;
   endsequence

   a_deselect_release: assert property (s_deselected |-> !o_miso_oe)
      else $error("slave out driven while deselected");
   a_oe_after_select: assert property ($rose(o_miso_oe) |-> !$past(i_chip_select_low, 2))
      else $error("slave out enabled without select");
   a_acquire_grant: assert property (i_enable && i_acquire && o_sem_status == 2'h1
      |=> s_cpu_grant) else $error("acquire by owner not granted at once");
   a_release_frees: assert property (i_enable && i_release && !i_acquire
      && i_chip_select_low && o_sem_status == 2'h1 |-> ##2 o_sem_status == 2'h0)
      else $error("release did not free the semaphore");
   a_disabled_cpu: assert property (!i_enable [*3]
      |-> o_sem_status == 2'h1 && !o_acquired_event && !o_end_event)
      else $error("disabled unit not parked with CPU");
   a_end_frees: assert property (o_end_event |=> o_sem_status != 2'h2)
      else $error("slave kept semaphore after end");
   a_short_hand: assert property (o_end_event && i_short_end_acquire
      && $past(i_short_end_acquire) |-> s_cpu_grant) else $error("shortcut handover missing");
   a_slave_no_grant: assert property (i_acquire && o_sem_status == 2'h2
      && !i_chip_select_low |=> !o_acquired_event [*2]) else $error("grant during slave hold");
   a_rx_window: assert property (o_rxm_wr
      |-> (o_rxm_addr - i_rx_buffer_pointer) < AW'(i_receive_limit))
      else $error("write beyond receive limit");
endmodule // sss_slave_properties

bind sss_slave sss_slave_properties #(.CNT_W(CNT_W), .AW(AW)) u_props (
   .i_mclk(i_mclk), .i_nrst(i_nrst), .i_enable(i_enable), .i_acquire(i_acquire),
   .i_release(i_release), .i_short_end_acquire(i_short_end_acquire),
   .i_chip_select_low(i_chip_select_low), .i_receive_limit(i_receive_limit),
   .i_rx_buffer_pointer(i_rx_buffer_pointer), .o_miso_oe(o_miso_oe), .o_rxm_wr(o_rxm_wr),
   .o_rxm_addr(o_rxm_addr), .o_acquired_event(o_acquired_event),
   .o_end_event(o_end_event), .o_sem_status(o_sem_status));

/* File: sim/sss_master_model.sv */
/* Behavioural serial master that frames and clocks bytes at 125 ns per bit.
   Assumes the bench loads tx_q and calls xfer only between frames. */
`timescale 1ns/100ps
module sss_master_model (
   input wire logic i_cpol,
   input wire logic i_cpha,
   input wire logic i_order,
   input wire logic i_miso,
   output logic o_cs_n,
   output logic o_sck,
   output logic o_mosi
);
   logic [7:0] tx_q [8];
   logic [7:0] rx_q [8];
   initial begin
      o_cs_n = 1'b1;
      o_sck = 1'b0;
      o_mosi = 1'b0;
   end
   task automatic xfer(input int n);
      int k;
      o_sck = i_cpol;
      #201 o_cs_n = 1'b0;
      #300;
      for (int i = 0; i < n * 8; i++) begin
         k = i_order ? i % 8 : 7 - i % 8;
         if (!i_cpha) o_mosi = tx_q[i / 8][k];
         #62.5 o_sck = ~i_cpol;
         if (i_cpha) o_mosi = tx_q[i / 8][k];
         else rx_q[i / 8][k] = i_miso;
         #62.5 o_sck = i_cpol;
         if (i_cpha) rx_q[i / 8][k] = i_miso;
      end
      #200 o_cs_n = 1'b1;
      // The released line flips so a stale level is never taken for data.
      o_mosi = ~o_mosi;
   endtask
endmodule // sss_master_model

/* File: sim/tb_sss_slave.sv */
/* Self-checking bench for sss_slave with RAM ports and a serial master model.
   Assumes the master model file and the bound checker are compiled alongside. */
`timescale 1ns/100ps
module tb_sss_slave;
   logic mclk, nrst, en, cpol, cpha, order, acq, rel, short_acq, clr_ovf, clr_ovr, stall;
   logic cs_n, sck, mosi, miso, oe, txm_rd, rxm_wr, acq_ev, end_ev, full_ev, ovf, ovr;
   logic [13:0] rx_lim, tx_lim, rx_cnt, tx_cnt;
   logic [31:0] txm_addr, rxm_addr;
   logic [7:0] txm_data, rxm_data;
   logic [31:0] rx_ptr, tx_ptr;
   logic [7:0] def_ch, orc_ch;
   logic [1:0] sem;
   logic [7:0] txm [64];
   logic [7:0] rxm [64];
   int mismatches, total_checks, n_end, n_acq, n_full, ne, na;

   sss_slave dut (.i_mclk(mclk), .i_nrst(nrst), .i_enable(en), .i_cpol(cpol), .i_cpha(cpha),
      .i_order(order), .i_acquire(acq), .i_release(rel), .i_short_end_acquire(short_acq),
      .i_clear_overflow(clr_ovf), .i_clear_tx_flag_a(clr_ovr), .i_receive_limit(rx_lim),
      .i_transmit_limit(tx_lim), .i_rx_buffer_pointer(rx_ptr), .i_tx_buffer_pointer(tx_ptr),
      .i_ignored_fill_char(def_ch), .i_tx_flag_a_fill_char(orc_ch), .i_chip_select_low(cs_n),
      .i_sck(sck), .i_mosi(mosi), .o_miso(miso), .o_miso_oe(oe), .o_txm_rd(txm_rd),
      .o_txm_addr(txm_addr), .i_txm_data(txm_data), .o_rxm_wr(rxm_wr), .o_rxm_addr(rxm_addr),
      .o_rxm_data(rxm_data), .i_rxm_ready(!stall), .o_acquired_event(acq_ev),
      .o_end_event(end_ev), .o_rx_buffer_full_event(full_ev), .o_sem_status(sem),
      .o_overflow(ovf), .o_tx_flag_a(ovr), .o_rx_byte_count(rx_cnt), .o_tx_byte_count(tx_cnt));
   sss_master_model m (.i_cpol(cpol), .i_cpha(cpha), .i_order(order),
      .i_miso(oe ? miso : !miso), .o_cs_n(cs_n), .o_sck(sck), .o_mosi(mosi));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (txm_rd === 1'b1) txm_data <= txm[txm_addr[5:0]];
      if (rxm_wr === 1'b1 && !stall) rxm[rxm_addr[5:0]] <= rxm_data;
      n_end += (end_ev === 1'b1);
      n_acq += (acq_ev === 1'b1);
      n_full += (full_ev === 1'b1);
   end

   function automatic logic [7:0] pat(input int i, input int md);
      return 8'(i * 37 + md + 1);
   endfunction
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task tk(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic pulse(ref logic s);
      tk(1);
      s = 1'b1;
      tk(1);
      s = 1'b0;
   endtask
   task finish_test;
      if (mismatches == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      {nrst, en, cpol, cpha, order, acq, rel, short_acq, clr_ovf, clr_ovr, stall} = '0;
      rx_lim = 14'h3;
      tx_lim = 14'h3;
      rx_ptr = 32'h20;
      tx_ptr = 32'h10;
      def_ch = 8'hE7;
      orc_ch = 8'h5C;
      for (int i = 0; i < 64; i++) begin
         txm[i] = 8'(i ^ 8'hA5);
         rxm[i] = 8'h00;
      end
      tk(5);
      nrst = 1'b1;
      tk(4);
      chk("sem", 2'h1, sem);
      en = 1'b1;
      tk(3);
      chk("acq_ev", 0, n_acq);
      pulse(acq);
      tk(3);
      chk("acq_ev", 1, n_acq);
      pulse(rel);
      tk(3);
      chk("sem", 2'h0, sem);
      pulse(rel);
      tk(3);
      chk("sem", 2'h0, sem);
      for (int md = 0; md < 4; md++) begin
         cpol = md[1];
         cpha = md[0];
         order = md[0] ^ md[1];
         for (int i = 0; i < 8; i++) m.tx_q[i] = pat(i, md);
         m.xfer(3);
         tk(15);
         for (int i = 0; i < 3; i++) begin
            chk("miso", txm[16 + i], m.rx_q[i]);
            chk("rx_ram", pat(i, md), rxm[32 + i]);
         end
         chk("end_ev", md + 1, n_end);
         chk("full_ev", md + 1, n_full);
         chk("rx_cnt", 3, rx_cnt);
         chk("tx_cnt", 3, tx_cnt);
         chk("sem", 2'h0, sem);
      end
      tx_lim = 14'h1;
      rx_lim = 14'h2;
      stall = 1'b1;
      tx_ptr = 32'h18;
      for (int i = 0; i < 8; i++) m.tx_q[i] = pat(i, 4);
      m.xfer(3);
      tk(15);
      chk("ovf", 1, ovf);
      chk("ovr", 1, ovr);
      chk("rx_cnt", 2, rx_cnt);
      chk("tx_cnt", 1, tx_cnt);
      stall = 1'b0;
      tk(10);
      for (int i = 0; i < 3; i++) begin
         chk("miso", i > 0 ? 8'h5C : txm[24], m.rx_q[i]);
         chk("rx_ram", pat(i, i < 2 ? 4 : 3), rxm[32 + i]);
      end
      pulse(clr_ovf);
      pulse(clr_ovr);
      tk(2);
      chk("ovf", 0, ovf);
      chk("ovr", 0, ovr);
      tx_lim = 14'h3;
      rx_lim = 14'h3;
      ne = n_end;
      pulse(acq);
      fork
         m.xfer(2);
         begin
            tk(60);
            pulse(rel);
         end
      join
      tk(15);
      chk("miso", 8'hE7, m.rx_q[0]);
      chk("miso", 8'hE7, m.rx_q[1]);
      chk("rx_ram", pat(0, 4), rxm[32]);
      chk("end_ev", ne, n_end);
      chk("sem", 2'h0, sem);
      short_acq = 1'b1;
      ne = n_end;
      na = n_acq;
      fork
         m.xfer(1);
         begin
            tk(80);
            pulse(acq);
            pulse(acq);
         end
      join
      tk(15);
      chk("acq_ev", na + 1, n_acq);
      chk("sem", 2'h1, sem);
      chk("end_ev", ne + 1, n_end);
      pulse(rel);
      tk(3);
      na = n_acq;
      en = 1'b0;
      tk(4);
      chk("sem", 2'h1, sem);
      chk("rx_cnt", 1, rx_cnt);
      en = 1'b1;
      tk(3);
      chk("sem", 2'h1, sem);
      chk("acq_ev", na, n_acq);
      finish_test();
   end

   // The tests need about 25 us; twelve times that means a hang.
   initial begin
      #300000;
      mismatches++;
      finish_test();
   end
endmodule // tb_sss_slave
